// file: design/ixc_defs.svh
// Constants for the expansion bus cycle control block
`ifndef IXC_DEFS_SVH
`define IXC_DEFS_SVH
`define IXC_PORT_CLK_ADDR 16'h0070
`define IXC_PORT_CLK_DATA 16'h0071
`define IXC_KBD_DATA 16'h0060
`define IXC_KBD_CMD 16'h0064
`define IXC_KBD_MASK 16'hFFF1
`define IXC_KBD_BASE 16'h0060
`define IXC_CMD_A20 8'hD1
`define IXC_CMD_RESET 8'hFE
`define IXC_BIT_A20 1
`define IXC_BIT_RST 0
`define IXC_POST_EN_BIT 7
`define IXC_REG_EN_BIT 7
`define IXC_RST_NS 320
`define IXC_CLK_NS 20
`define IXC_RST_CYC ((`IXC_RST_NS + `IXC_CLK_NS - 1) / `IXC_CLK_NS)
`define IXC_BUF_BYTES 4
`endif

// file: design/ixc_pkg.sv
// Types for the expansion bus cycle control block
package ixc_pkg;
  typedef enum logic [3:0] {
    IXC_IDLE = 4'b0001,
    IXC_FLUSH = 4'b0010,
    IXC_PCI = 4'b0100,
    IXC_WAIT = 4'b1000
  } ixc_state_e;
  typedef logic [7:0] ixc_byte_t;
endpackage : ixc_pkg

// file: design/ixc_cycle_ctrl.sv
// Expansion bus cycle control: posted writes, register access, peripheral strobes
// Overview of operation
// - Posting off after reset; on only with control bit 7 of index 50h.
// - Posted writes gather in four-byte buffer; no PCI write before flush.
// - Flush on full, miss, overwrite, other cycle, or master release.
// - Cycle causing a flush is stalled with ready low until flush completes.
// - Flush writes may carry non-contiguous byte enables.
// - Internal register cycles go to PCI first; register used only if unclaimed.
// - Peripheral register accesses hold ready low at least programmed count.
// - Other internal register access blocked unless bit 7 of index 51h set.
// - Peripheral bus uses shared lines as 8-bit subset with 8-bit timing.
// - Clock/ROM select low on IO 70h/71h access and on ROM hit during memory write or IO read.
// - Clock address strobe high during IO write to 70h.
// - Clock write pulse low during IO write to 71h.
// - Clock read strobe low during IO read of 71h.
// - Clock interrupt input inverted toward interrupt controller.
// - Even ports 60h to 6Eh decode as keyboard accesses.
// - Non-intercepted keyboard writes and all reads drive write/read and select low.
// - Intercepted keyboard writes keep write strobe and select high.
// - Data write after D1h command sets A20 mask to data bit 1.
// - Writing FEh to 64h gives a fast host reset.
// - Data write after D1h with bit 0 zero also gives fast reset.
// - Fast reset pulse lasts at least 16 clocks.
`timescale 1ns/1ps
`include "ixc_defs.svh"
module ixc_cycle_ctrl
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [15:0] isa_addr,
  input wire ixc_pkg::ixc_byte_t isa_data,
  input wire logic iow_in_n,
  input wire logic ior_in_n,
  input wire logic memw_n,
  input wire logic host_mem_hit,
  input wire logic rom_hit,
  input wire logic master_release,
  input wire logic pc_reg_hit,
  input wire logic other_reg_hit,
  input wire ixc_pkg::ixc_byte_t index_50h,
  input wire ixc_pkg::ixc_byte_t index_51h,
  input wire ixc_pkg::ixc_byte_t index_01h,
  input wire logic pci_done,
  input wire logic pci_claimed,
  input wire logic clock_chip_irq_in_n,
  output logic iochrdy,
  output logic pci_wr_req,
  output logic [31:0] pci_wr_addr,
  output logic [31:0] pci_wr_data,
  output logic [3:0] pci_wr_be,
  output logic pci_cyc_req,
  output logic reg_access,
  output logic reg_blocked,
  output logic iow_out_n,
  output logic ior_out_n,
  output logic rom_clock_chip_select_n,
  output logic clock_chip_addr_strobe,
  output logic clock_chip_write_n,
  output logic clock_chip_read_strobe,
  output logic keyboard_select_n,
  output logic clock_irq,
  output logic core_addr_bit20_mask_n,
  output logic cpu_fast_reset
);
  import ixc_pkg::*;

  function automatic logic kbd_hit(input logic [15:0] a);
    kbd_hit = (a & `IXC_KBD_MASK) == `IXC_KBD_BASE;
  endfunction : kbd_hit

  // Pin synchronisers
  logic [15:0] a_s1_r, a_s2_r;
  logic [7:0] d_s1_r, d_s2_r;
  logic [12:0] c_s1_r, c_s2_r;
  logic [12:0] c_in;
  assign c_in = {iow_in_n, ior_in_n, memw_n, host_mem_hit, rom_hit, master_release,
    pc_reg_hit, other_reg_hit, pci_done, pci_claimed, clock_chip_irq_in_n,
    index_50h[`IXC_POST_EN_BIT], index_51h[`IXC_REG_EN_BIT]};
  logic [7:0] wcnt_s1_r, wcnt_s2_r;
  always_ff @(posedge ref_clk)
  begin
    a_s1_r <= isa_addr;
    a_s2_r <= a_s1_r;
    d_s1_r <= isa_data;
    d_s2_r <= d_s1_r;
    c_s1_r <= c_in;
    c_s2_r <= c_s1_r;
    wcnt_s1_r <= index_01h;
    wcnt_s2_r <= wcnt_s1_r;
  end

  logic iow, ior, memw, hmem, rom, rel, pcr, otr, done, claim, irq_n, post_en, reg_en;
  assign {iow, ior, memw, hmem, rom, rel, pcr, otr, done, claim, irq_n, post_en, reg_en} =
    {~c_s2_r[12], ~c_s2_r[11], ~c_s2_r[10], c_s2_r[9:0]};

  logic memw_d_r, cyc_d_r, rel_d_r;
  logic cyc_act, post_start, cyc_start, rel_rise;
  assign cyc_act = iow | ior | memw;
  assign cyc_start = cyc_act & ~cyc_d_r;
  assign post_start = memw & ~memw_d_r & hmem & post_en;
  assign rel_rise = rel & ~rel_d_r;

  // Posted write buffer and cycle state
  ixc_state_e st_r, st_nxt;
  logic [29:0] buf_addr_r, buf_addr_nxt;
  logic [31:0] buf_data_r, buf_data_nxt;
  logic [3:0] buf_be_r, buf_be_nxt;
  logic [7:0] wait_r, wait_nxt;
  logic held_r, held_nxt;
  logic [1:0] lane;
  assign lane = a_s2_r[1:0];

  always_comb
  begin
    st_nxt = st_r;
    buf_addr_nxt = buf_addr_r;
    buf_data_nxt = buf_data_r;
    buf_be_nxt = buf_be_r;
    wait_nxt = wait_r;
    held_nxt = held_r;
    unique case (st_r)
      IXC_IDLE:
      begin
        if (post_start && (buf_be_r == 4'h0 ||
            (buf_addr_r == {14'h0000, a_s2_r[15:2]} && !buf_be_r[lane])))
        begin
          buf_addr_nxt = {14'h0000, a_s2_r[15:2]};
          buf_data_nxt[lane*8 +: 8] = d_s2_r;
          buf_be_nxt[lane] = 1'b1;
        end
        else if (buf_be_r != 4'h0 && (cyc_start || rel_rise))
        begin
          st_nxt = IXC_FLUSH;
          held_nxt = cyc_start;
        end
        else if (buf_be_r == 4'hF)
        begin
          st_nxt = IXC_FLUSH;
          held_nxt = 1'b0;
        end
        else if (cyc_start && memw && hmem && !post_en)
        begin
          buf_addr_nxt = {14'h0000, a_s2_r[15:2]};
          buf_data_nxt[lane*8 +: 8] = d_s2_r;
          buf_be_nxt = 4'h0;
          buf_be_nxt[lane] = 1'b1;
          st_nxt = IXC_FLUSH;
          held_nxt = 1'b1;
        end
        else if (cyc_start && (pcr || (otr && reg_en)))
          st_nxt = IXC_PCI;
      end
      IXC_FLUSH:
        if (done)
        begin
          buf_be_nxt = 4'h0;
          st_nxt = IXC_IDLE;
          held_nxt = 1'b0;
          // Stalled host write is posted once the old data is out
          if (held_r && memw && hmem && post_en)
          begin
            buf_addr_nxt = {14'h0000, a_s2_r[15:2]};
            buf_data_nxt[lane*8 +: 8] = d_s2_r;
            buf_be_nxt[lane] = 1'b1;
          end
        end
      IXC_PCI:
        if (done)
        begin
          st_nxt = IXC_WAIT;
          wait_nxt = pcr ? wcnt_s2_r : 8'h00;
        end
      IXC_WAIT:
        if (wait_r == 8'h00)
          st_nxt = IXC_IDLE;
        else
          wait_nxt = wait_r - 8'h01;
      default:
        st_nxt = IXC_IDLE;
    endcase
  end

  logic reg_acc_r, reg_acc_nxt;
  assign reg_acc_nxt = (st_r == IXC_PCI) && done && !claim;

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      st_r <= IXC_IDLE;
      buf_addr_r <= 30'h0;
      buf_data_r <= 32'h0;
      buf_be_r <= 4'h0;
      wait_r <= 8'h00;
      held_r <= 1'b0;
      reg_acc_r <= 1'b0;
      memw_d_r <= 1'b0;
      cyc_d_r <= 1'b0;
      rel_d_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      buf_addr_r <= buf_addr_nxt;
      buf_data_r <= buf_data_nxt;
      buf_be_r <= buf_be_nxt;
      wait_r <= wait_nxt;
      held_r <= held_nxt;
      reg_acc_r <= reg_acc_nxt;
      memw_d_r <= memw;
      cyc_d_r <= cyc_act;
      rel_d_r <= rel;
    end
  end

  assign iochrdy = !((st_r == IXC_FLUSH && held_r) || st_r == IXC_PCI
    || st_r == IXC_WAIT);
  assign pci_wr_req = (st_r == IXC_FLUSH);
  assign pci_wr_addr = {buf_addr_r, 2'b00};
  assign pci_wr_data = buf_data_r;
  assign pci_wr_be = buf_be_r;
  assign pci_cyc_req = (st_r == IXC_PCI);
  assign reg_access = reg_acc_r;
  assign reg_blocked = cyc_start && otr && !reg_en;

  // Peripheral bus strobes, 8-bit subset of shared lines
  logic pend_r, pend_nxt, a20_r, a20_nxt, icpt_r, icpt_nxt;
  logic kbd, kbd_wr_int, io70, io71, kwr, kwr_d_r, icpt_now;
  logic [4:0] rcnt_r, rcnt_nxt;
  assign kbd = kbd_hit(a_s2_r);
  assign io70 = a_s2_r == `IXC_PORT_CLK_ADDR;
  assign io71 = a_s2_r == `IXC_PORT_CLK_DATA;
  assign kwr = iow && kbd && !kwr_d_r;
  assign icpt_now = (a_s2_r == `IXC_KBD_CMD) || (a_s2_r == `IXC_KBD_DATA && pend_r);
  // Intercept decision held for the whole write
  assign kbd_wr_int = iow && kbd && (kwr ? icpt_now : icpt_r);

  // Keyboard emulation state
  always_comb
  begin
    pend_nxt = pend_r;
    icpt_nxt = kwr ? icpt_now : (icpt_r && iow && kbd);
    a20_nxt = a20_r;
    rcnt_nxt = (rcnt_r != 5'd0) ? rcnt_r - 5'd1 : 5'd0;
    if (kwr && a_s2_r == `IXC_KBD_CMD)
    begin
      pend_nxt = (d_s2_r == `IXC_CMD_A20);
      if (d_s2_r == `IXC_CMD_RESET)
        rcnt_nxt = 5'(`IXC_RST_CYC);
    end
    else if (kwr && a_s2_r == `IXC_KBD_DATA && pend_r)
    begin
      pend_nxt = 1'b0;
      a20_nxt = d_s2_r[`IXC_BIT_A20];
      if (!d_s2_r[`IXC_BIT_RST])
        rcnt_nxt = 5'(`IXC_RST_CYC);
    end
  end
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      pend_r <= 1'b0;
      a20_r <= 1'b1;
      rcnt_r <= 5'd0;
      kwr_d_r <= 1'b0;
      icpt_r <= 1'b0;
    end
    else
    begin
      icpt_r <= icpt_nxt;
      pend_r <= pend_nxt;
      a20_r <= a20_nxt;
      rcnt_r <= rcnt_nxt;
      kwr_d_r <= iow && kbd;
    end
  end

  assign core_addr_bit20_mask_n = a20_r;
  assign cpu_fast_reset = rcnt_r != 5'd0;
  assign rom_clock_chip_select_n = !(((iow || ior) && (io70 || io71)) || (rom
    && (memw || ior)));
  assign clock_chip_addr_strobe = iow && io70;
  assign clock_chip_write_n = !(iow && io71);
  assign clock_chip_read_strobe = !(ior && io71);
  assign keyboard_select_n = !((ior && kbd) || (iow && kbd && !kbd_wr_int));
  assign iow_out_n = !(iow && !(kbd && kbd_wr_int));
  assign ior_out_n = !ior;
  assign clock_irq = !irq_n;

  property p_reset_len;
    @(posedge ref_clk) disable iff (!rst_n)
      $rose(cpu_fast_reset) |-> cpu_fast_reset [*8] ##1 cpu_fast_reset [*8];
  endproperty : p_reset_len
  a_reset_len: assert property (p_reset_len) else $error("fast reset too short");
  // Label names below
  property p_a20_reset;
    @(posedge ref_clk) $rose(rst_n) |-> core_addr_bit20_mask_n && !pend_r;
  endproperty : p_a20_reset
  a_a20_reset: assert property (p_a20_reset) else $error("bad reset state");
  property p_flush_stall;
    @(posedge ref_clk) disable iff (!rst_n) (st_r == IXC_FLUSH && held_r) |-> !iochrdy;
  endproperty
  a_flush_stall: assert property (p_flush_stall) else $error("flush not stalled");
  property p_no_post;
    @(posedge ref_clk) disable iff (!rst_n) (!post_en && buf_be_r != 4'h0) |-> st_r == IXC_FLUSH;
  endproperty
  a_no_post: assert property (p_no_post) else $error("posted while disabled");
  property p_wr_pulse;
    @(posedge ref_clk) disable iff (!rst_n) (iow && io71) |-> !clock_chip_write_n;
  endproperty
  a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse missing");
  property p_intercept;
    @(posedge ref_clk) disable iff (!rst_n) (iow && a_s2_r == `IXC_KBD_CMD)
      |-> keyboard_select_n && iow_out_n;
  endproperty
  a_intercept: assert property (p_intercept) else $error("intercept leaked");
  property p_fe_reset;
    @(posedge ref_clk) disable iff (!rst_n)
      (kwr && a_s2_r == `IXC_KBD_CMD && d_s2_r == `IXC_CMD_RESET) |=> cpu_fast_reset;
  endproperty
  a_fe_reset: assert property (p_fe_reset) else $error("no fast reset");
  property p_blocked;
    @(posedge ref_clk) disable iff (!rst_n) (cyc_start && otr && !pcr && !reg_en
      && st_r == IXC_IDLE && buf_be_r == 0) |=> st_r != IXC_PCI;
  endproperty
  a_blocked: assert property (p_blocked) else $error("register not blocked");
endmodule : ixc_cycle_ctrl

// file: testbench/ixc_pci_model.sv
// PCI side responder for the cycle control block
`timescale 1ns/1ps
module ixc_pci_model
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pci_wr_req,
  input wire logic pci_cyc_req,
  output logic pci_done,
  output logic pci_claimed
);
  logic [2:0] cnt_r;
  logic hold_r;
  logic tog_r;
  // Claim only qualified by done; no target ever claims
  assign pci_claimed = pci_done ? 1'b0 : tog_r;
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= 3'h0;
      hold_r <= 1'b0;
      pci_done <= 1'b0;
      tog_r <= 1'b0;
    end
    else
    begin
      tog_r <= ~tog_r;
      pci_done <= 1'b0;
      if (hold_r)
        hold_r <= pci_wr_req | pci_cyc_req;
      else if (pci_wr_req | pci_cyc_req)
      begin
        cnt_r <= cnt_r + 3'h1;
        if (cnt_r == 3'h3)
        begin
          pci_done <= 1'b1;
          hold_r <= 1'b1;
          cnt_r <= 3'h0;
        end
      end
    end
  end
endmodule : ixc_pci_model

// file: testbench/tb.sv
// Self-checking bench for the cycle control block
`timescale 1ns/1ps
`include "ixc_defs.svh"
module tb;
  import ixc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [15:0] isa_addr = 16'h0000;
  ixc_byte_t isa_data = 8'h00;
  ixc_byte_t index_51h = 8'h00;
  logic iow_in_n = 1'b1, ior_in_n = 1'b1, memw_n = 1'b1, host_mem_hit = 1'b0, rom_hit = 1'b0;
  logic other_reg_hit = 1'b0, irq_n = 1'b1, pci_done, pci_claimed, iochrdy, pci_wr_req;
  logic [31:0] pci_wr_addr, pci_wr_data;
  logic [3:0] pci_wr_be;
  logic pci_cyc_req, reg_access, reg_blocked, iow_out_n, ior_out_n, cs_n, as, wr_n, rd_n;
  logic kb_n, clock_irq, a20_n, cpu_fast_reset;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  int rst_cnt = 0;
  ixc_cycle_ctrl uut (.ref_clk(ref_clk), .rst_n(rst_n), .isa_addr(isa_addr),
    .isa_data(isa_data), .iow_in_n(iow_in_n), .ior_in_n(ior_in_n), .memw_n(memw_n),
    .host_mem_hit(host_mem_hit), .rom_hit(rom_hit), .master_release(1'b0),
    .pc_reg_hit(1'b0), .other_reg_hit(other_reg_hit), .index_50h(8'h00),
    .index_51h(index_51h), .index_01h(8'h02), .pci_done(pci_done),
    .pci_claimed(pci_claimed), .clock_chip_irq_in_n(irq_n), .iochrdy(iochrdy),
    .pci_wr_req(pci_wr_req), .pci_wr_addr(pci_wr_addr), .pci_wr_data(pci_wr_data),
    .pci_wr_be(pci_wr_be), .pci_cyc_req(pci_cyc_req), .reg_access(reg_access),
    .reg_blocked(reg_blocked), .iow_out_n(iow_out_n), .ior_out_n(ior_out_n),
    .rom_clock_chip_select_n(cs_n), .clock_chip_addr_strobe(as),
    .clock_chip_write_n(wr_n), .clock_chip_read_strobe(rd_n), .keyboard_select_n(kb_n),
    .clock_irq(clock_irq), .core_addr_bit20_mask_n(a20_n), .cpu_fast_reset(cpu_fast_reset));
  ixc_pci_model partner (.ref_clk(ref_clk), .rst_n(rst_n), .pci_wr_req(pci_wr_req),
    .pci_cyc_req(pci_cyc_req), .pci_done(pci_done), .pci_claimed(pci_claimed));
  initial
  begin
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cpu_fast_reset === 1'b1)
      rst_cnt++;
    if (cycles == 6000)
    begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  // Kind 0 io write, 1 io read, 2 memory write
  task automatic start(input int kind, input logic [15:0] a, input ixc_byte_t d);
    isa_addr = a;
    isa_data = d;
    iow_in_n = (kind != 0);
    ior_in_n = (kind != 1);
    memw_n = (kind != 2);
  endtask : start
  task automatic stop();
    iow_in_n = 1'b1;
    ior_in_n = 1'b1;
    memw_n = 1'b1;
    isa_data = ~isa_data;
    tick(6);
  endtask : stop
  function automatic logic pick(input int s);
    case (s)
      0: return pci_wr_req;
      1: return reg_blocked;
      default: return reg_access;
    endcase
  endfunction : pick
  task automatic wait_hi(input int s, input string msg);
    for (int i = 0; i < 40 && pick(s) !== 1'b1; i++)
      tick(1);
    check(pick(s), 1'b1, msg);
  endtask : wait_hi
  task automatic kbd_io(input logic [15:0] a, input ixc_byte_t d, input logic [1:0] exp);
    start(0, a, d);
    tick(4);
    check({kb_n, iow_out_n}, exp, "keyboard write strobes wrong");
    stop();
  endtask : kbd_io
  task automatic s_clock();
    start(0, `IXC_PORT_CLK_ADDR, 8'h0A);
    tick(4);
    check({as, cs_n}, 2'b10, "clock address cycle strobes");
    stop();
    start(0, `IXC_PORT_CLK_DATA, 8'h55);
    tick(4);
    check({wr_n, cs_n, as}, 3'b000, "clock write cycle strobes");
    stop();
    start(1, `IXC_PORT_CLK_DATA, 8'h00);
    tick(4);
    check({rd_n, cs_n, wr_n}, 3'b001, "clock read cycle strobes");
    stop();
    check({as, wr_n, rd_n, cs_n}, 4'b0111, "clock strobes idle");
    rom_hit = 1'b1;
    start(2, 16'h0000, 8'h11);
    tick(4);
    check(cs_n, 1'b0, "rom select");
    stop();
    rom_hit = 1'b0;
  endtask : s_clock
  task automatic s_kbd();
    for (int i = 0; i < 8; i++)
    begin
      start(1, `IXC_KBD_BASE + 16'(2 * i), 8'h00);
      tick(4);
      check({ior_out_n, kb_n}, 2'b00, "keyboard read");
      stop();
    end
    start(0, 16'h0062, 8'h33);
    tick(4);
    check({iow_out_n, kb_n}, 2'b00, "keyboard write passed");
    stop();
  endtask : s_kbd
  task automatic s_emul(input ixc_byte_t cmd, input ixc_byte_t d, input logic a20,
      input logic rst);
    rst_cnt = 0;
    kbd_io(`IXC_KBD_CMD, `IXC_CMD_A20, 2'b11);
    if (cmd != `IXC_CMD_A20)
      kbd_io(`IXC_KBD_CMD, cmd, 2'b11);
    kbd_io(`IXC_KBD_DATA, d, (cmd == `IXC_CMD_A20) ? 2'b11 : 2'b00);
    tick(25);
    check(a20_n, a20, "mask level after data write");
    check(rst_cnt >= 16, rst, "fast reset length");
  endtask : s_emul
  task automatic s_reg();
    other_reg_hit = 1'b1;
    start(0, 16'h0024, 8'h01);
    wait_hi(1, "register access not blocked");
    stop();
    tick(2);
    index_51h = 8'h80;
    start(0, 16'h0024, 8'h02);
    wait_hi(2, "unclaimed register cycle not done");
    stop();
    other_reg_hit = 1'b0;
  endtask : s_reg
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    tick(10);
    rst_n = 1'b1;
    tick(3);
    check({a20_n, cpu_fast_reset}, 2'b10, "reset state");
    irq_n = 1'b0;
    tick(4);
    check(clock_irq, 1'b1, "irq not inverted");
    irq_n = 1'b1;
    tick(4);
    check(clock_irq, 1'b0, "irq idle");
    s_clock();
    s_kbd();
    s_emul(`IXC_CMD_A20, 8'h00, 1'b0, 1'b1);
    s_emul(`IXC_CMD_A20, 8'h03, 1'b1, 1'b0);
    s_emul(8'hAA, 8'h00, 1'b1, 1'b0);
    rst_cnt = 0;
    kbd_io(`IXC_KBD_CMD, `IXC_CMD_RESET, 2'b11);
    tick(25);
    check(rst_cnt >= 16, 1'b1, "command reset");
    host_mem_hit = 1'b1;
    start(2, 16'h0010, 8'h5A);
    wait_hi(0, "unposted write not issued");
    check(pci_wr_data[7:0], 8'h5A, "write lane data");
    check(pci_wr_addr[15:0], 16'h0010, "write address");
    check(pci_wr_be, 4'h1, "write byte enables");
    check(iochrdy, 1'b0, "write cycle not stalled");
    stop();
    host_mem_hit = 1'b0;
    s_reg();
    tally_and_finish();
  end
endmodule : tb
